/* src/iot_core.sv */
// Transceiver, queue buffers and program-visible registers of the I/O processor
`default_nettype none
module iot_core (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire iot_pkg::iot_op_t op,
  input wire iot_pkg::iot_host_t host,
  input wire logic [iot_pkg::WORD_W-1:0] host_memory_data_bus,
  input wire logic [iot_pkg::WORD_W-1:0] peripheral_side_bus,
  input wire logic [7:0] peripheral_sense_lines,
  output logic [iot_pkg::HALF_W-1:0] periph_out_half,
  output logic [iot_pkg::WORD_W-1:0] periph_out_word,
  output logic periph_out_strobe,
  output logic [iot_pkg::WORD_W-1:0] queue_word,
  output logic queue_full,
  output logic queue_valid,
  output logic [iot_pkg::REG_W-1:0] a_operand,
  output logic [iot_pkg::REG_W-1:0] b_operand,
  output logic [iot_pkg::REG_W-1:0] work_value,
  output logic [iot_pkg::PTR_W-1:0] jump_target,
  output logic [iot_pkg::WORD_W-1:0] host_link_word,
  output logic [iot_pkg::WORD_W-1:0] ps_store_word,
  output logic [iot_pkg::REG_W-1:0] control_status_word,
  output logic [iot_pkg::REG_W-1:0] device_command_out,
  output logic [4:0] alu_status,
  output logic sense_bit,
  output logic flag_bit,
  output logic [7:0] user_flags
);
  import iot_pkg::*;

  logic [REG_W-1:0] alu_ram [DEPTH];
  logic [REG_W-1:0] work_q;
  logic [PTR_W-1:0] ptr_q;
  logic [WORD_W-1:0] link_q;
  logic [REG_W-1:0] csw_q;
  logic [REG_W-1:0] cmd_q;
  logic [7:0] flags_q;
  logic [WORD_W-1:0] in_buf_q;
  logic in_buf_full_q;
  logic [WORD_W-1:0] out_buf_q;
  logic [1:0] out_phase_q;
  logic out_busy_q;
  logic [HALF_W-1:0] half_q;
  logic [WORD_W-1:0] word_q;
  logic strobe_q;
  logic [REG_W-1:0] a_q;
  logic [REG_W-1:0] b_q;
  logic sense_q;
  logic flag_q;
  logic [WORD_W-1:0] q_rdata;
  logic q_full;
  logic q_valid;
  logic q_adv;
  logic host_hit;
  iot_fmt_t fmt;
  logic [1:0] last_phase;

  // Format select held in the low control bits
  assign fmt = iot_fmt_t'(csw_q[1:0]);
  assign host_hit = (host.dev == HOST_DEV_NUM);

  // Program-driven pops only; a read waits out the pieces of the previous word
  assign q_adv = op.q_skip || (op.q_read && !out_busy_q);

  iot_queue u_queue (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .wr(in_buf_full_q),
    .wdata(in_buf_q),
    .adv(q_adv),
    .rdata(q_rdata),
    .full(q_full),
    .valid(q_valid)
  );

  // Input buffer register, one word per load
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      in_buf_q <= WORD_ZERO;
      in_buf_full_q <= 1'b0;
    end else begin
      in_buf_full_q <= 1'b0;
      if (op.q_load && !q_full) begin
        in_buf_q <= (op.q_src == SRC_HOST) ? host_memory_data_bus : peripheral_side_bus;
        in_buf_full_q <= 1'b1;
      end else if (op.dst == TD_QUEUE && !q_full) begin
        in_buf_q <= place_field(op.fld, WORD_ZERO, op.data);
        in_buf_full_q <= 1'b1;
      end
    end
  end

  // Output format logic: passes a word whole in FMT_FULL, else splits it into halves per format
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      out_buf_q <= WORD_ZERO;
      out_phase_q <= 2'h0;
      out_busy_q <= 1'b0;
      half_q <= '0;
      word_q <= WORD_ZERO;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= 1'b0;
      if (out_busy_q) begin
        strobe_q <= 1'b1;
        case (fmt)
          FMT_FULL: word_q <= out_buf_q;
          FMT_THREE: begin
            case (out_phase_q)
              2'h0: half_q <= {6'h00, out_buf_q[CHAR_LSB +: CHAR_W]};
              2'h1: half_q <= {2'h0, out_buf_q[UMAN_LSB +: UMAN_W]};
              default: half_q <= {2'h0, out_buf_q[LMAN_LSB +: LMAN_W]};
            endcase
          end
          FMT_TRUNC_MAN: begin
            // Low mantissa bits dropped
            half_q <= (out_phase_q == 2'h0) ? {6'h00, out_buf_q[CHAR_LSB +: CHAR_W]} :
                      {2'h0, out_buf_q[UMAN_LSB +: UMAN_W]};
          end
          default: begin
            // Characteristic dropped, 28 mantissa bits in two halves
            half_q <= (out_phase_q == 2'h0) ? {2'h0, out_buf_q[UMAN_LSB +: UMAN_W]} :
                      {2'h0, out_buf_q[LMAN_LSB +: LMAN_W]};
          end
        endcase
        if (out_phase_q == last_phase) begin
          out_busy_q <= 1'b0;
          out_phase_q <= 2'h0;
        end else begin
          out_phase_q <= out_phase_q + 2'h1;
        end
      end else if (op.q_read && q_valid && !op.q_skip) begin
        out_buf_q <= q_rdata;
        out_busy_q <= 1'b1;
      end
    end
  end

  always_comb begin
    case (fmt)
      FMT_FULL: last_phase = 2'h0;
      FMT_THREE: last_phase = 2'h2;
      default: last_phase = 2'h1;
    endcase
  end

  // Operand RAM, written at the B address
  always_ff @(posedge sys_clk) begin
    if (op.alu_we) begin
      alu_ram[op.b_addr] <= op.alu_result;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      a_q <= '0;
      b_q <= '0;
    end else begin
      a_q <= alu_ram[op.a_addr];
      b_q <= alu_ram[op.b_addr];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      work_q <= '0;
    end else if (op.work_we && op.expanded) begin
      work_q <= op.alu_result;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ptr_q <= '0;
    end else if (op.dst == TD_POINTER) begin
      ptr_q <= op.data[PTR_W-1:0];
    end
  end

  // Host link word: program write wins a same-cycle collision
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      link_q <= WORD_ZERO;
    end else if (op.ps_fetch) begin
      link_q <= op.ps_data;
    end else if (op.dst == TD_LINK) begin
      link_q <= place_field(op.fld, link_q, op.data);
    end else if (host.we && host_hit) begin
      link_q <= host.wdata;
    end
  end

  // Control word: load-value beats transfer; status bits follow the ALU
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      csw_q <= CSW_RESET;
    end else begin
      if (op.csw_value_we) begin
        csw_q <= op.value;
      end else if (op.dst == TD_CONTROL) begin
        csw_q <= op.data[REG_W-1:0];
      end
      if (op.status_we) begin
        csw_q[CSW_STAT_LSB +: 5] <= op.alu_status;
      end
      csw_q[CSW_VALID_BIT] <= q_valid;
      csw_q[CSW_FULL_BIT] <= q_full;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cmd_q <= '0;
    end else if (op.dst == TD_COMMAND) begin
      cmd_q <= op.data[REG_W-1:0];
    end
  end

  // Flags: host writes first, program set/clear override it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flags_q <= 8'h00;
    end else begin
      logic [7:0] f;
      f = flags_q;
      if (host.flag_we) begin
        f = host.flag_wdata;
      end
      if (op.flag_op == FOP_SET) begin
        f[op.flag_sel] = 1'b1;
      end else if (op.flag_op == FOP_CLEAR) begin
        f[op.flag_sel] = 1'b0;
      end
      flags_q <= f;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sense_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      sense_q <= peripheral_sense_lines[op.sense_sel];
      flag_q <= flags_q[op.flag_sel];
    end
  end

  assign periph_out_half = half_q;
  assign periph_out_word = word_q;
  assign periph_out_strobe = strobe_q;
  assign queue_word = out_buf_q;
  assign queue_full = csw_q[CSW_FULL_BIT];
  assign queue_valid = csw_q[CSW_VALID_BIT];
  assign a_operand = a_q;
  assign b_operand = b_q;
  assign work_value = work_q;
  assign jump_target = ptr_q;
  assign host_link_word = link_q;
  assign ps_store_word = link_q;
  assign control_status_word = csw_q;
  assign device_command_out = cmd_q;
  assign alu_status = csw_q[CSW_STAT_LSB +: 5];
  assign sense_bit = sense_q;
  assign flag_bit = flag_q;
  assign user_flags = flags_q;
endmodule
`default_nettype wire

/* src/iot_pkg.sv */
// Package: constants and carrier types of the I/O transceiver and register block
`default_nettype none
package iot_pkg;
  localparam int WORD_W = 38;
  localparam int HALF_W = 16;
  localparam int REG_W = 20;
  localparam int PTR_W = 8;
  localparam int DEPTH = 16;
  localparam int IDX_W = 4;
  localparam int CHAR_W = 10;
  localparam int UMAN_W = 14;
  localparam int LMAN_W = 14;
  localparam int CHAR_LSB = 28;
  localparam int UMAN_LSB = 14;
  localparam int LMAN_LSB = 0;
  localparam logic [9:0] HOST_DEV_NUM = 10'h064;
  localparam int CSW_STAT_LSB = 11;
  localparam int CSW_VALID_BIT = 6;
  localparam int CSW_FULL_BIT = 5;
  localparam logic [REG_W-1:0] CSW_RESET = 20'h00000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 38'h0000000000;

  typedef enum logic [1:0] {FMT_FULL, FMT_THREE, FMT_TRUNC_MAN, FMT_TRUNC_CHAR} iot_fmt_t;
  typedef enum logic [1:0] {SRC_PERIPH, SRC_HOST} iot_src_t;
  typedef enum logic [2:0] {
    TD_NONE, TD_POINTER, TD_QUEUE, TD_LINK, TD_CONTROL, TD_COMMAND, TD_WORK
  } iot_dst_t;
  typedef enum logic [1:0] {FLD_WHOLE, FLD_CHAR, FLD_UMAN, FLD_LMAN} iot_fld_t;
  typedef enum logic [1:0] {FOP_NONE, FOP_SET, FOP_CLEAR} iot_fop_t;

  // One program step as decoded by the sequencer
  typedef struct packed {
    logic alu_we;
    logic [IDX_W-1:0] a_addr;
    logic [IDX_W-1:0] b_addr;
    logic [REG_W-1:0] alu_result;
    logic [4:0] alu_status;
    logic status_we;
    logic expanded;
    logic work_we;
    iot_dst_t dst;
    iot_fld_t fld;
    logic [WORD_W-1:0] data;
    logic csw_value_we;
    logic [REG_W-1:0] value;
    logic q_load;
    iot_src_t q_src;
    logic q_read;
    logic q_skip;
    iot_fop_t flag_op;
    logic [2:0] flag_sel;
    logic [2:0] sense_sel;
    logic ps_fetch;
    logic [WORD_W-1:0] ps_data;
  } iot_op_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [9:0] dev;
    logic [WORD_W-1:0] wdata;
    logic flag_we;
    logic [7:0] flag_wdata;
  } iot_host_t;

  function automatic logic [WORD_W-1:0] place_field(iot_fld_t f, logic [WORD_W-1:0] old,
                                                   logic [WORD_W-1:0] d);
    logic [WORD_W-1:0] r;
    r = old;
    case (f)
      FLD_WHOLE: r = d;
      FLD_CHAR: r[CHAR_LSB +: CHAR_W] = d[CHAR_W-1:0];
      FLD_UMAN: r[UMAN_LSB +: UMAN_W] = d[UMAN_W-1:0];
      default: r[LMAN_LSB +: LMAN_W] = d[LMAN_W-1:0];
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

/* src/iot_queue.sv */
// Sixteen-entry first-in first-out word store with skip
`default_nettype none
module iot_queue (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic wr,
  input wire logic [iot_pkg::WORD_W-1:0] wdata,
  input wire logic adv,
  output logic [iot_pkg::WORD_W-1:0] rdata,
  output logic full,
  output logic valid
);
  import iot_pkg::*;
  logic [WORD_W-1:0] mem [DEPTH];
  logic [IDX_W-1:0] wp_q;
  logic [IDX_W-1:0] rp_q;
  logic [IDX_W:0] cnt_q;
  logic do_wr;
  logic do_rd;

  assign full = (cnt_q == (IDX_W+1)'(DEPTH));
  assign valid = (cnt_q != '0);
  assign do_wr = wr && !full;
  assign do_rd = adv && valid;
  assign rdata = mem[rp_q];

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wp_q] <= wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_wr) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_rd) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (IDX_W+1)'(do_wr) - (IDX_W+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

/* verification/iot_core_assertions.sv */
// Port-level checks of the transceiver and register block
`default_nettype none
module iot_core_assertions (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire iot_pkg::iot_op_t op,
  input wire iot_pkg::iot_host_t host,
  input wire logic [7:0] peripheral_sense_lines,
  input wire logic queue_full,
  input wire logic queue_valid,
  input wire logic [iot_pkg::REG_W-1:0] work_value,
  input wire logic [iot_pkg::PTR_W-1:0] jump_target,
  input wire logic [iot_pkg::WORD_W-1:0] host_link_word,
  input wire logic [iot_pkg::REG_W-1:0] control_status_word,
  input wire logic [iot_pkg::REG_W-1:0] device_command_out,
  input wire logic [4:0] alu_status,
  input wire logic sense_bit,
  input wire logic [7:0] user_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  import iot_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_reset_clears: assert property (disable iff (1'b0)
    !rstn |=> control_status_word == CSW_RESET && user_flags == 8'h00
    && host_link_word == WORD_ZERO) else $error("reset value wrong");
  a_pointer_load: assert property (op.dst == TD_POINTER |=>
    jump_target == $past(op.data[PTR_W-1:0])) else $error("pointer not loaded");
  a_command_load: assert property (op.dst == TD_COMMAND |=>
    device_command_out == $past(op.data[REG_W-1:0])) else $error("command not loaded");
  a_value_control: assert property (op.csw_value_we |=>
    control_status_word[1:0] == $past(op.value[1:0])) else $error("control value lost");
  a_flag_set: assert property (op.flag_op == FOP_SET |=>
    user_flags[$past(op.flag_sel)]) else $error("flag not set");
  a_flag_clear: assert property (op.flag_op == FOP_CLEAR |=>
    !user_flags[$past(op.flag_sel)]) else $error("flag not cleared");
  a_host_flags: assert property (host.flag_we && op.flag_op == FOP_NONE |=>
    user_flags == $past(host.flag_wdata)) else $error("host flag write lost");
  a_host_link: assert property (host.we && host.dev == HOST_DEV_NUM
    && op.dst != TD_LINK && !op.ps_fetch |=> host_link_word == $past(host.wdata))
    else $error("host link write lost");
  a_work_guard: assert property ($changed(work_value) |->
    $past(op.expanded) && $past(op.work_we))
    else $error("work register changed outside expanded format");
  a_status_copy: assert property (op.status_we |=>
    alu_status == $past(op.alu_status)) else $error("status bits not loaded");
  a_sense_pick: assert property (rstn |=>
    sense_bit == $past(peripheral_sense_lines[op.sense_sel])) else $error("sense select wrong");
  a_full_valid: assert property (queue_full |-> queue_valid)
    else $error("full without valid");
endmodule
`default_nettype wire

/* verification/iot_core_bench.sv */
// Self-checking bench of the transceiver and register block
`default_nettype none
module iot_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import iot_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, drive = 1'b0;
  iot_op_t op = '0, o;
  iot_host_t host = '0, h;
  logic [WORD_W-1:0] md = WORD_ZERO, word_set = WORD_ZERO, psb, qw, hl, ps_out;
  logic [7:0] sense_set = 8'h00, psl, pieces, uf;
  logic [HALF_W-1:0] ph;
  logic [WORD_W-1:0] pw;
  logic ps, qf, qv, sb, fb;
  logic [REG_W-1:0] ao, bo, wv, csw, dco;
  logic [PTR_W-1:0] jt;
  logic [4:0] als;
  int n_fail = 0, checks = 0;
  always #5 sys_clk = ~sys_clk;
  iot_core i_iot_core (.sys_clk(sys_clk), .rstn(rstn), .op(op), .host(host),
    .host_memory_data_bus(md), .peripheral_side_bus(psb), .peripheral_sense_lines(psl),
    .periph_out_half(ph), .periph_out_word(pw), .periph_out_strobe(ps), .queue_word(qw),
    .queue_full(qf), .queue_valid(qv), .a_operand(ao), .b_operand(bo), .work_value(wv),
    .jump_target(jt), .host_link_word(hl), .ps_store_word(ps_out), .control_status_word(csw),
    .device_command_out(dco), .alu_status(als), .sense_bit(sb), .flag_bit(fb), .user_flags(uf));
  iot_far_side i_iot_far_side (.sys_clk(sys_clk), .drive(drive), .word_set(word_set),
    .sense_set(sense_set), .periph_out_strobe(ps), .peripheral_side_bus(psb),
    .peripheral_sense_lines(psl), .pieces(pieces));
  task automatic stop_test();
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string name, logic [WORD_W-1:0] exp, logic [WORD_W-1:0] got);
    checks++;
    if (exp !== got) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask
  // One step, then an idle cycle so outputs up to two register stages past the step have settled
  task automatic drv(iot_op_t a, iot_host_t b);
    op = a;
    host = b;
    @(negedge sys_clk);
    op = '0;
    host = '0;
    @(negedge sys_clk);
  endtask
  task automatic t_regs();
    chk("csw reset", CSW_RESET, csw);
    o = '0; o.dst = TD_POINTER; o.data = 38'h00000000A5; drv(o, '0);
    chk("pointer", 8'hA5, jt);
    o.dst = TD_COMMAND; o.data = 38'h00000ABCDE; drv(o, '0);
    chk("command", 20'hABCDE, dco);
    o.dst = TD_LINK; o.data = 38'h2A5A5A5A5A; drv(o, '0);
    chk("link", 38'h2A5A5A5A5A, hl);
    o.fld = FLD_CHAR; o.data = 38'h00000003FF; drv(o, '0);
    chk("link char", 38'h3FFA5A5A5A, hl);
    o = '0; o.ps_fetch = 1'b1; o.ps_data = 38'h1234567890; drv(o, '0);
    chk("fetch", 38'h1234567890, hl);
    chk("store word", 38'h1234567890, ps_out);
    o = '0; o.csw_value_we = 1'b1; o.value = 20'h00001; o.dst = TD_CONTROL; o.data = 38'h2;
    drv(o, '0);
    chk("value wins", 2'h1, csw[1:0]);
  endtask
  task automatic t_host();
    h = '0; h.we = 1'b1; h.dev = HOST_DEV_NUM; h.wdata = 38'h0F0F0F0F0F; drv('0, h);
    chk("host link", 38'h0F0F0F0F0F, hl);
    h.dev = 10'h065; h.wdata = 38'h1111111111; drv('0, h);
    chk("other dev", 38'h0F0F0F0F0F, hl);
    o = '0; o.dst = TD_LINK; o.data = 38'h0000000077; h.dev = HOST_DEV_NUM; drv(o, h);
    chk("program wins", 38'h0000000077, hl);
    h = '0; h.flag_we = 1'b1; h.flag_wdata = 8'h5A; drv('0, h);
    chk("host flags", 8'h5A, uf);
    o = '0; o.flag_op = FOP_SET; o.flag_sel = 3'h0; drv(o, '0);
    chk("set flag", 8'h5B, uf);
    o.flag_op = FOP_CLEAR; o.flag_sel = 3'h1; drv(o, '0);
    chk("clear flag", 8'h59, uf);
    o.flag_op = FOP_SET; o.flag_sel = 3'h7; h.flag_wdata = 8'h00; drv(o, h);
    chk("flag clash", 8'h80, uf);
  endtask
  task automatic t_alu();
    o = '0; o.alu_we = 1'b1; o.b_addr = 4'h0; o.alu_result = 20'h12345; drv(o, '0);
    o.b_addr = 4'hF; o.alu_result = 20'hFEDCB; drv(o, '0);
    op.a_addr = 4'hF; op.b_addr = 4'h0;
    @(negedge sys_clk);
    chk("ram a", 20'hFEDCB, ao);
    chk("ram b", 20'h12345, bo);
    o = '0; o.work_we = 1'b1; o.alu_result = 20'h0F0F0; drv(o, '0);
    chk("work guard", 20'h00000, wv);
    o.expanded = 1'b1; drv(o, '0);
    chk("work load", 20'h0F0F0, wv);
    o = '0; o.status_we = 1'b1; o.alu_status = 5'h15; drv(o, '0);
    chk("alu status", 5'h15, als);
    sense_set = 8'hA5;
    for (int i = 0; i < 8; i++) begin
      op.sense_sel = 3'(i);
      @(negedge sys_clk);
      chk("sense", sense_set[i], sb);
    end
    op = '0;
  endtask
  // Word loaded at index i alternates between the two sources
  task automatic load(int i);
    o = '0; o.q_load = 1'b1; o.q_src = i[0] ? SRC_HOST : SRC_PERIPH;
    drive = !i[0]; word_set = 38'h2000000001 + 38'(i); md = word_set;
    drv(o, '0);
    drive = 1'b0;
  endtask
  task automatic t_queue();
    logic [7:0] p0;
    for (int f = 0; f < 4; f++) begin
      o = '0; o.csw_value_we = 1'b1; o.value = 20'(f); drv(o, '0);
      p0 = pieces;
      load(0);
      repeat (4) @(negedge sys_clk);
      o = '0; o.q_read = 1'b1; drv(o, '0);
      repeat (4) @(negedge sys_clk);
      chk("pieces", f == 0 ? 8'h01 : (f == 1 ? 8'h03 : 8'h02), pieces - p0);
    end
    chk("last half", 16'h0001, ph);
    o = '0; o.csw_value_we = 1'b1; drv(o, '0);
    for (int i = 0; i < 19; i++) load(i);
    repeat (4) @(negedge sys_clk);
    chk("full", 1'b1, qf);
    for (int k = 0; k < 16; k++) begin
      o = '0; o.q_skip = (k == 4); o.q_read = (k != 4); drv(o, '0);
      if (k != 4) begin
        chk("queue order", 38'h2000000001 + 38'(k), qw);
        chk("periph word", 38'h2000000001 + 38'(k), pw);
      end
    end
    repeat (2) @(negedge sys_clk);
    chk("not full", 1'b0, qf);
    chk("drained", 1'b0, qv);
    o = '0; o.q_read = 1'b1; drv(o, '0);
    chk("empty read", 38'h2000000010, qw);
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    t_regs();
    t_host();
    t_alu();
    t_queue();
    stop_test();
  end
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule
bind iot_core iot_core_assertions i_iot_core_assertions (.sys_clk(sys_clk), .rstn(rstn),
  .op(op), .host(host), .peripheral_sense_lines(peripheral_sense_lines),
  .queue_full(queue_full), .queue_valid(queue_valid), .work_value(work_value),
  .jump_target(jump_target), .host_link_word(host_link_word),
  .control_status_word(control_status_word), .device_command_out(device_command_out),
  .alu_status(alu_status), .sense_bit(sense_bit), .user_flags(user_flags));
`default_nettype wire

/* verification/iot_far_side.sv */
// Far side model: peripheral word source, sense lines and piece counter
`default_nettype none
module iot_far_side (
  input wire logic sys_clk,
  input wire logic drive,
  input wire logic [iot_pkg::WORD_W-1:0] word_set,
  input wire logic [7:0] sense_set,
  input wire logic periph_out_strobe,
  output logic [iot_pkg::WORD_W-1:0] peripheral_side_bus,
  output logic [7:0] peripheral_sense_lines,
  output logic [7:0] pieces
);
  timeunit 1ns;
  timeprecision 1ps;
  import iot_pkg::*;
  logic [WORD_W-1:0] last_q = WORD_ZERO;
  logic [7:0] cnt_q = 8'h00;
  // Released bus shows inverted last word so stale data cannot pass
  assign peripheral_side_bus = drive ? word_set : ~last_q;
  assign peripheral_sense_lines = sense_set;
  assign pieces = cnt_q;
  always @(posedge sys_clk) begin
    if (drive) last_q <= word_set;
    if (periph_out_strobe) cnt_q <= cnt_q + 8'h01;
  end
endmodule
`default_nettype wire
